// ---- rtl/dma_channel.sv ----
// one dma channel: registers, address walk, block counting
`include "dma_defs.svh"
module dma_channel
    import dma_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        wr_i,        // write to this channel
    input  wire logic [2:0]  reg_i,       // register index
    input  wire logic [15:0] wdata_i,
    input  wire logic [127:0] req_vec_i,  // all request lines
    input  wire logic        grant_i,     // one transfer done this cycle
    input  wire logic [15:0] periph_off_i,// offset from the peripheral
    output logic             pending_o,
    output logic             block_done_o,// one-cycle interrupt event
    output logic [15:0]      ram_addr_o,
    output logic [15:0]      ctrl_o,
    output logic [15:0]      req_o,
    output logic [15:0]      sta_o,
    output logic [15:0]      stb_o,
    output logic [15:0]      pad_o,
    output logic [15:0]      cnt_o,
    output logic             buf_sel_o    // 1 while secondary buffer used
);
    // ************************************************************
    // state
    // ************************************************************
    logic [15:0] ctrl_q;       // control register
    logic [6:0]  sel_q;        // request number
    logic        force_q;      // manual start bit
    logic [15:0] sta_q;        // primary start
    logic [15:0] stb_q;        // secondary start
    logic [15:0] pad_q;        // peripheral address
    logic [9:0]  cnt_q;        // transfers per block minus one
    logic [9:0]  done_q;       // transfers done in block
    logic [15:0] off_q;        // running ram offset
    logic        pp_q;         // ping-pong buffer select
    logic        pend_q;       // transfer waiting for the bus
    logic        pp_seen_q;    // one-shot ping-pong: first block done
    logic        req_q;        // previous request level
    logic        en;
    logic        last;
    logic        half_pt;
    opmode_t     mode;
    addressing_mode_t      addressing_mode;

    assign en      = ctrl_q[`CTL_ENABLE];
    assign mode    = opmode_t'(ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO]);
    assign addressing_mode   = addressing_mode_t'(ctrl_q[`CTL_ADDRESSING_MODE_HI:`CTL_ADDRESSING_MODE_LO]);
    assign last    = (done_q == cnt_q);
    assign half_pt = (done_q == {1'b0, cnt_q[9:1]});

    // ************************************************************
    // register writes
    // ************************************************************
    // unused control bits never stored, so they read zero
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= `RESET_WORD;
            sel_q  <= 7'h00;
            sta_q  <= `RESET_WORD;
            stb_q  <= `RESET_WORD;
            pad_q  <= `RESET_WORD;
            cnt_q  <= 10'h000;
        end
        else if (wr_i)
        begin
            unique case (reg_i)
                `REG_CONTROL:     ctrl_q <= wdata_i & `CTL_WRITE_MASK;
                `REG_REQ_SELECT:  sel_q  <= wdata_i[6:0];
                `REG_PRIMARY:     sta_q  <= wdata_i;
                `REG_SECONDARY:   stb_q  <= wdata_i;
                `REG_PERIPH_ADDR: pad_q  <= wdata_i;
                `REG_COUNT:       cnt_q  <= wdata_i[9:0];
                default:          ;
            endcase
        end
        else if (grant_i && last && pp_q && pp_seen_q)
        begin
            // second buffer of a one-shot ping-pong pair ends the run
            ctrl_q[`CTL_ENABLE] <= 1'b0;
        end
        else if (grant_i && last && (mode == MODE_ONESHOT))
        begin
            ctrl_q[`CTL_ENABLE] <= 1'b0;
        end
    end

    // ************************************************************
    // force bit: software sets, hardware clears
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            force_q <= 1'b0;
        else if (wr_i && reg_i == `REG_REQ_SELECT && wdata_i[`REQ_FORCE])
            force_q <= 1'b1;
        else if (grant_i)
            force_q <= 1'b0;
    end

    // ************************************************************
    // trigger: rising edge of selected request or manual force
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            req_q  <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            req_q <= req_vec_i[sel_q];
            // set wins over the grant clear
            if (en && ((req_vec_i[sel_q] && !req_q) ||
                       (wr_i && reg_i == `REG_REQ_SELECT && wdata_i[`REQ_FORCE])))
                pend_q <= 1'b1;
            else if (grant_i || !en)
                pend_q <= 1'b0;
        end
    end

    // ************************************************************
    // address walk and block end
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            done_q    <= 10'h000;
            off_q     <= `RESET_WORD;
            pp_q      <= 1'b0;
            pp_seen_q <= 1'b0;
        end
        else if (wr_i && reg_i == `REG_CONTROL)
        begin
            // reprogramming restarts the block
            done_q    <= 10'h000;
            off_q     <= `RESET_WORD;
            pp_q      <= 1'b0;
            pp_seen_q <= 1'b0;
        end
        else if (grant_i)
        begin
            if (last)
            begin
                done_q <= 10'h000;
                off_q  <= `RESET_WORD;
                if (mode == MODE_CONT_PP || mode == MODE_ONESHOT_PP)
                begin
                    pp_q      <= ~pp_q;
                    pp_seen_q <= (mode == MODE_ONESHOT_PP) && !pp_q;
                end
            end
            else
            begin
                done_q <= done_q + 10'h001;
                if (addressing_mode == ADDRESSING_MODE_POST_INC)
                    off_q <= off_q + (ctrl_q[`CTL_SIZE] ? 16'h0001 : 16'h0002);
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb
    begin
        if (addressing_mode == ADDRESSING_MODE_PERIPH)
            ram_addr_o = (pp_q ? stb_q : sta_q) + periph_off_i;
        else
            ram_addr_o = (pp_q ? stb_q : sta_q) + off_q;
    end

    // interrupt at half point or at end
    assign block_done_o = grant_i && (ctrl_q[`CTL_HALF] ? half_pt : last);
    assign pending_o    = pend_q && en;
    assign ctrl_o       = ctrl_q;
    assign req_o        = {force_q, 8'h00, sel_q};
    assign sta_o        = sta_q;
    assign stb_o        = stb_q;
    assign pad_o        = pad_q;
    assign cnt_o        = {6'h00, cnt_q};
    assign buf_sel_o    = pp_q;
endmodule

// ---- rtl/dma_controller.sv ----
// eight-channel peripheral dma controller with fixed-priority bus grant
// Operation
// - eight identical channels with own registers
// - transfers use own bus, not cpu
// - bit 15 enables the channel
// - bit 14 selects byte or word
// - bit 13 selects transfer direction
// - bit 12 moves interrupt to half block
// - bit 11 adds null peripheral write when bit 13 is clear
// - bits 5-4 select ram addressing mode
// - bits 1-0 select block mode
// - one-shot stops after one block, except when a register write to the channel meets its last transfer
// - continuous reloads start address each block
// - ping-pong alternates primary and secondary buffers
// - peripheral indirect takes offset from peripheral
// - per-channel interrupt at block end or half
// - start by peripheral request or software
// - trigger chosen from peripheral request sources
// - 10-bit transfer count per channel
// - 16-bit start and peripheral address registers
// - two status registers shared by channels
// - unused control bits read zero
// - force starts one transfer, hardware clears
// - 7-bit request select per channel
`include "dma_defs.svh"
module dma_controller
    import dma_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // register port
    input  wire logic [5:0]   addr_i,       // {channel, register}
    input  wire logic [15:0]  wdata_i,
    input  wire logic         wr_i,
    input  wire logic         rd_i,
    output logic [15:0]       rdata_o,
    // peripheral requests and indirect offset
    input  wire logic [127:0] req_vec_i,
    input  wire logic [15:0]  periph_off_i,
    // dedicated dma bus
    output logic              bus_valid_o,
    output logic [2:0]        bus_chan_o,
    output logic              bus_ram_wr_o,  // 1: ram written, 0: ram read
    output logic              bus_per_wr_o,  // peripheral written
    output logic              bus_null_o,    // peripheral write carries zero
    output logic              bus_byte_o,
    output logic [15:0]       bus_ram_addr_o,
    output logic [15:0]       bus_per_addr_o,
    output logic [7:0]        irq_o          // per-channel block events
);
    // ************************************************************
    // channel wires
    // ************************************************************
    logic [7:0]  pend;                    // channel wants the bus
    logic [7:0]  grant;                   // one-hot grant
    logic [7:0]  done;                    // block event per channel
    logic [7:0]  bufsel;                  // ping-pong buffer per channel
    logic [7:0]  chan_wr;                 // register write per channel
    logic [15:0] ram_addr [8];
    logic [15:0] ctrl     [8];
    logic [15:0] reqr     [8];
    logic [15:0] sta      [8];
    logic [15:0] stb      [8];
    logic [15:0] pad      [8];
    logic [15:0] cnt      [8];
    logic [2:0]  win;                     // winning channel
    logic [2:0]  sel_ch;                  // addressed channel
    logic [2:0]  sel_reg;                 // addressed register
    logic [7:0]  overrun_q;               // request seen while pending
    logic [7:0]  last_buf_q;              // buffer of last completed block

    assign sel_ch  = addr_i[5:3];
    assign sel_reg = addr_i[2:0];

    // ************************************************************
    // eight channels
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g++)
        begin : g_chan
            assign chan_wr[g] = wr_i && (sel_ch == 3'(g));
            dma_channel u_chan (
                .clk_i        (clk_i),
                .rst_n_i      (rst_n_i),
                .wr_i         (chan_wr[g]),
                .reg_i        (sel_reg),
                .wdata_i      (wdata_i),
                .req_vec_i    (req_vec_i),
                .grant_i      (grant[g]),
                .periph_off_i (periph_off_i),
                .pending_o    (pend[g]),
                .block_done_o (done[g]),
                .ram_addr_o   (ram_addr[g]),
                .ctrl_o       (ctrl[g]),
                .req_o        (reqr[g]),
                .sta_o        (sta[g]),
                .stb_o        (stb[g]),
                .pad_o        (pad[g]),
                .cnt_o        (cnt[g]),
                .buf_sel_o    (bufsel[g])
            );
        end
    endgenerate

    // ************************************************************
    // fixed priority arbiter
    // ************************************************************
    // lowest index wins; the rest wait, so no channel is starved of
    // correctness but high channels may wait under heavy load
    always_comb
    begin
        grant = 8'h00;
        win   = 3'h0;
        for (int i = `NUM_CHANNELS - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                win = 3'(i);
            end
        end
        if (pend != 8'h00)
            grant[win] = 1'b1;
    end

    // ************************************************************
    // dma bus drive, registered
    // ************************************************************
    // separate bus from the cpu register port, never stalls software
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            bus_valid_o    <= 1'b0;
            bus_chan_o     <= 3'h0;
            bus_ram_wr_o   <= 1'b0;
            bus_per_wr_o   <= 1'b0;
            bus_null_o     <= 1'b0;
            bus_byte_o     <= 1'b0;
            bus_ram_addr_o <= `RESET_WORD;
            bus_per_addr_o <= `RESET_WORD;
        end
        else
        begin
            bus_valid_o    <= (pend != 8'h00);
            bus_chan_o     <= win;
            // direction: 1 ram to peripheral, 0 peripheral to ram
            bus_ram_wr_o   <= !ctrl[win][`CTL_DIR];
            // null write only with direction clear
            bus_per_wr_o   <= ctrl[win][`CTL_DIR] ||
                              (ctrl[win][`CTL_NULL_WRITE_ENABLE] && !ctrl[win][`CTL_DIR]);
            bus_null_o     <= ctrl[win][`CTL_NULL_WRITE_ENABLE] && !ctrl[win][`CTL_DIR];
            bus_byte_o     <= ctrl[win][`CTL_SIZE];
            bus_ram_addr_o <= ram_addr[win];
            bus_per_addr_o <= pad[win];
        end
    end

    // ************************************************************
    // interrupt events, one-cycle pulses per channel
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_o <= 8'h00;
        else
            irq_o <= done;
    end

    // ************************************************************
    // shared status: overrun flags and last buffer
    // ************************************************************
    // overrun: request arrived while the previous one still waited;
    // set wins over a software clear (write ones to clear)
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            overrun_q  <= 8'h00;
            last_buf_q <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < `NUM_CHANNELS; i++)
            begin
                if (pend[i] && !grant[i] && req_vec_i[reqr[i][6:0]])
                    overrun_q[i] <= 1'b1;
                else if (wr_i && sel_reg == `REG_SHARED_0 && wdata_i[i])
                    overrun_q[i] <= 1'b0;
                if (done[i])
                    last_buf_q[i] <= bufsel[i];
            end
        end
    end

    // ************************************************************
    // register read, data one cycle after strobe
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            rdata_o <= `RESET_WORD;
        else if (rd_i)
        begin
            unique case (sel_reg)
                `REG_CONTROL:     rdata_o <= ctrl[sel_ch];
                `REG_REQ_SELECT:  rdata_o <= reqr[sel_ch];
                `REG_PRIMARY:     rdata_o <= sta[sel_ch];
                `REG_SECONDARY:   rdata_o <= stb[sel_ch];
                `REG_PERIPH_ADDR: rdata_o <= pad[sel_ch];
                `REG_COUNT:       rdata_o <= cnt[sel_ch];
                `REG_SHARED_0:    rdata_o <= {8'h00, overrun_q};
                `REG_SHARED_1:    rdata_o <= {5'h00, win, last_buf_q};
            endcase
        end
        else
            rdata_o <= `RESET_WORD;
    end
endmodule

// ---- rtl/dma_defs.svh ----
// register offsets, field positions, reset values and widths of the dma block
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// ************************************************************
// register map: index = {channel, register}; registers 6 and 7 shared by all channels
// ************************************************************
`define REG_CONTROL        3'h0
`define REG_REQ_SELECT     3'h1
`define REG_PRIMARY        3'h2
`define REG_SECONDARY      3'h3
`define REG_PERIPH_ADDR    3'h4
`define REG_COUNT          3'h5
`define REG_SHARED_0       3'h6
`define REG_SHARED_1       3'h7

// ************************************************************
// control register fields
// ************************************************************
`define CTL_ENABLE         15
`define CTL_SIZE           14
`define CTL_DIR            13
`define CTL_HALF           12
`define CTL_NULL_WRITE_ENABLE          11
`define CTL_ADDRESSING_MODE_HI       5
`define CTL_ADDRESSING_MODE_LO       4
`define CTL_MODE_HI        1
`define CTL_MODE_LO        0
`define CTL_WRITE_MASK     16'hF833
`define REQ_FORCE          15
`define REQ_SEL_MASK       16'h007F

// ************************************************************
// reset values and sizes
// ************************************************************
`define RESET_WORD         16'h0000
`define COUNT_MASK         16'h03FF
`define NUM_CHANNELS       8
`define NUM_REQUESTS       128

`endif

// ---- rtl/dma_pkg.sv ----
// types shared by the dma channel and the dma controller
package dma_pkg;
    // ram addressing choice
    typedef enum logic [1:0] {
        ADDRESSING_MODE_POST_INC,
        ADDRESSING_MODE_NO_INC,
        ADDRESSING_MODE_PERIPH,
        ADDRESSING_MODE_RESERVED
    } addressing_mode_t;

    // block mode choice
    typedef enum logic [1:0] {
        MODE_CONT,
        MODE_ONESHOT,
        MODE_CONT_PP,
        MODE_ONESHOT_PP
    } opmode_t;
endpackage

// ---- tb/dma_monitor.sv ----
// port checker of the dma controller
`include "dma_defs.svh"
module dma_monitor (
    input wire logic         clk_i,
    input wire logic         rst_n_i,
    input wire logic [5:0]   addr_i,
    input wire logic [15:0]  wdata_i,
    input wire logic         wr_i,
    input wire logic         rd_i,
    input wire logic [15:0]  rdata_o,
    input wire logic [127:0] req_vec_i,
    input wire logic [15:0]  periph_off_i,
    input wire logic         bus_valid_o,
    input wire logic [2:0]   bus_chan_o,
    input wire logic         bus_ram_wr_o,
    input wire logic         bus_per_wr_o,
    input wire logic         bus_null_o,
    input wire logic         bus_byte_o,
    input wire logic [15:0]  bus_ram_addr_o,
    input wire logic [15:0]  bus_per_addr_o,
    input wire logic [7:0]   irq_o
);
    // ******************************************
    // one clock domain, reset disables all
    // ******************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_irq_with_bus: assert property (irq_o != 8'h00 |-> bus_valid_o)
        else $error("block event without transfer");
    chk_irq_own_chan: assert property (irq_o != 8'h00 |-> irq_o == (8'h01 << bus_chan_o))
        else $error("block event on wrong channel");
    chk_null_both: assert property (bus_valid_o && bus_null_o |-> bus_ram_wr_o && bus_per_wr_o)
        else $error("null write without ram write");
    chk_dir_one_side: assert property (bus_valid_o && !bus_null_o |-> bus_ram_wr_o ^ bus_per_wr_o)
        else $error("direction not exclusive");
    chk_ctrl_reserved: assert property (rd_i && addr_i[2:0] == `REG_CONTROL |=> (rdata_o & ~`CTL_WRITE_MASK) == 16'h0000)
        else $error("reserved control bits set");
    chk_count_width: assert property (rd_i && addr_i[2:0] == `REG_COUNT |=> rdata_o[15:10] == 6'h00)
        else $error("count wider than ten bits");
    chk_req_reserved: assert property (rd_i && addr_i[2:0] == `REG_REQ_SELECT |=> rdata_o[14:7] == 8'h00)
        else $error("request select reserved bits set");
    chk_reset_quiet: assert property (!$past(rst_n_i) |-> !bus_valid_o && irq_o == 8'h00)
        else $error("activity right after reset");
endmodule

bind dma_controller dma_monitor mon_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req_vec_i(req_vec_i),
    .periph_off_i(periph_off_i), .bus_valid_o(bus_valid_o), .bus_chan_o(bus_chan_o),
    .bus_ram_wr_o(bus_ram_wr_o), .bus_per_wr_o(bus_per_wr_o), .bus_null_o(bus_null_o),
    .bus_byte_o(bus_byte_o), .bus_ram_addr_o(bus_ram_addr_o),
    .bus_per_addr_o(bus_per_addr_o), .irq_o(irq_o));

// ---- tb/multichannel_peripheral_dma_bench.sv ----
// self-checking bench of the dma controller
`include "dma_defs.svh"
`define CHECK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t %s", $time, msg); end end
module multichannel_peripheral_dma_bench
    import dma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_i = 1'b0;
    logic         rst_n_i;
    logic [5:0]   addr_i;
    logic [15:0]  wdata_i, rdata_o, periph_off_i, bus_ram_addr_o, bus_per_addr_o;
    logic         wr_i, rd_i, bus_valid_o, bus_ram_wr_o, bus_per_wr_o, bus_null_o, bus_byte_o;
    logic [127:0] req_vec_i;
    logic [2:0]   bus_chan_o;
    logic [7:0]   irq_o;
    logic         fire;          // request pulse to the model
    logic [6:0]   line;
    logic [15:0]  off, sa, sb, pa;
    logic [46:0]  bq[$];         // expected transfers, oldest first
    logic [15:0]  rq[$];         // expected read data
    logic [46:0]  e;
    logic         rd_prev = 1'b0;
    int           bad_count = 0;
    int           comparisons = 0;
    always #10 clk_i = ~clk_i;   // 50 MHz
    dma_controller dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .req_vec_i(req_vec_i), .periph_off_i(periph_off_i), .bus_valid_o(bus_valid_o),
        .bus_chan_o(bus_chan_o), .bus_ram_wr_o(bus_ram_wr_o), .bus_per_wr_o(bus_per_wr_o),
        .bus_null_o(bus_null_o), .bus_byte_o(bus_byte_o), .bus_ram_addr_o(bus_ram_addr_o),
        .bus_per_addr_o(bus_per_addr_o), .irq_o(irq_o));
    periph_model per_u (.clk_i(clk_i), .fire_i(fire), .line_i(line), .off_i(off),
        .req_vec_o(req_vec_i), .periph_off_o(periph_off_i));
    // ******************************************
    // watchers: pop oldest note per result
    // ******************************************
    always @(posedge clk_i)
    begin
        if (rd_prev)
            `CHECK(rdata_o, rq.pop_front(), "read data")
        rd_prev = (rd_i === 1'b1);
        if (bus_valid_o === 1'b1)
        begin
            e = bq.size() ? bq.pop_front() : 47'h0;    // empty queue: stray transfer
            `CHECK({bus_chan_o, bus_null_o, bus_ram_wr_o, bus_per_wr_o, bus_byte_o,
                bus_ram_addr_o, bus_per_addr_o, irq_o}, e, "transfer")
        end
    end
    task automatic wr(input logic [2:0] ch, input logic [2:0] r, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= {ch, r};
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] ch, input logic [2:0] r, input logic [15:0] x);
        rq.push_back(x);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= {ch, r};
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // control register last: it restarts the block
    task automatic setup(input logic [2:0] ch, input logic [15:0] c, input logic [15:0] a,
                         input logic [15:0] b, input logic [15:0] n);
        wr(ch, `REG_PRIMARY, a);
        wr(ch, `REG_SECONDARY, b);
        wr(ch, `REG_PERIPH_ADDR, pa);
        wr(ch, `REG_COUNT, n);
        wr(ch, `REG_CONTROL, c);
    endtask
    task automatic exp(input logic [2:0] ch, input logic [3:0] k, input logic [15:0] ra,
                       input logic [7:0] iq);
        bq.push_back({ch, k, ra, pa, iq});
    endtask
    // bounded wait for all notes, then room for strays
    task automatic drain();
        repeat (40) if (bq.size() != 0) @(posedge clk_i);
        if (bq.size() != 0)
            `CHECK(bq.size(), 0, "missing transfer")
        bq.delete();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic fd(input logic [2:0] ch);
        wr(ch, `REG_REQ_SELECT, 16'h807F);   // unused line 127 keeps it manual
        drain();
    endtask
    task automatic pulse(input logic [6:0] l);
        @(posedge clk_i);
        fire <= 1'b1;
        line <= l;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask
    function automatic logic [15:0] mk(input logic sz, dr, nw, input addressing_mode_t am,
                                       input opmode_t md);
        return {1'b1, sz, dr, 1'b0, nw, 5'h00, am, 2'h0, md};
    endfunction
    task automatic conclude();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        conclude();
    end
    // ******************************************
    // main sequence
    // ******************************************
    initial
    begin
        {wr_i, rd_i, fire, rst_n_i} = 4'h0;
        {addr_i, wdata_i, line, off} = 45'h0;
        void'($urandom(32'h9523));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        sa = 16'($urandom) & 16'hFFF0;
        sb = 16'($urandom) & 16'hFFF0;
        pa = 16'($urandom);
        for (int r = 0; r < 8; r++) rd(3'h7, 3'(r), 16'h0000);
        wr(3'h0, `REG_CONTROL, 16'h77CC);
        rd(3'h0, `REG_CONTROL, 16'h7000);
        wr(3'h0, `REG_COUNT, 16'hFFFF);
        rd(3'h0, `REG_COUNT, 16'h03FF);
        // one-shot: one block, enable and force drop, then deaf
        setup(3'h0, mk(0, 0, 0, ADDRESSING_MODE_POST_INC, MODE_ONESHOT), sa, sb, 16'h0000);
        exp(3'h0, 4'b0100, sa, 8'h01);
        fd(3'h0);
        rd(3'h0, `REG_CONTROL, 16'h4001 & 16'h0001);
        rd(3'h0, `REG_REQ_SELECT, 16'h007F);
        fd(3'h0);
        // bytes step by one, block reloads
        setup(3'h2, mk(1, 0, 0, ADDRESSING_MODE_POST_INC, MODE_CONT) | 16'h1000, sa, sb, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            exp(3'h2, 4'b0101, sa + 16'(i == 1), (i != 1) ? 8'h04 : 8'h00);
            fd(3'h2);
        end
        // ping-pong continuous then one-shot
        for (int m = 0; m < 2; m++)
        begin
            setup(3'h3, mk(0, 0, 0, ADDRESSING_MODE_POST_INC, m ? MODE_ONESHOT_PP : MODE_CONT_PP),
                  sa, sb, 16'h0000);
            for (int i = 0; i < 3; i++)
            begin
                if (m == 0 || i < 2)
                    exp(3'h3, 4'b0100, i[0] ? sb : sa, 8'h08);
                fd(3'h3);
            end
        end
        // peripheral indirect, ram to peripheral
        off <= 16'($urandom) & 16'h00FE;
        setup(3'h4, mk(0, 1, 0, ADDRESSING_MODE_PERIPH, MODE_CONT), sa, sb, 16'h0000);
        exp(3'h4, 4'b0010, sa + off, 8'h10);
        fd(3'h4);
        // null write beside ram write, address held
        setup(3'h5, mk(0, 0, 1, ADDRESSING_MODE_NO_INC, MODE_CONT), sa, sb, 16'h0001);
        for (int i = 0; i < 2; i++)
        begin
            exp(3'h5, 4'b1110, sa, i ? 8'h20 : 8'h00);
            fd(3'h5);
        end
        // shared request line: lower channel first; disabled one ignored
        setup(3'h1, mk(0, 0, 0, ADDRESSING_MODE_POST_INC, MODE_CONT), sa, sb, 16'h0003);
        setup(3'h6, mk(0, 0, 0, ADDRESSING_MODE_POST_INC, MODE_CONT), sb, sb, 16'h0003);
        wr(3'h1, `REG_REQ_SELECT, 16'h000D);
        wr(3'h6, `REG_REQ_SELECT, 16'h000D);
        wr(3'h7, `REG_REQ_SELECT, 16'h000D);
        exp(3'h1, 4'b0100, sa, 8'h00);
        exp(3'h6, 4'b0100, sb, 8'h00);
        pulse(7'h0D);
        drain();
        for (int j = 0; j < 2; j++)
        begin
            wr(3'h6, `REG_REQ_SELECT, j ? 16'h0000 : 16'h0046);
            exp(3'h6, 4'b0100, sb + 16'(2 * j + 2), 8'h00);
            pulse(j ? 7'h00 : 7'h46);
            drain();
        end
        // only channel 3 finished its last block in the secondary buffer
        rd(3'h0, `REG_SHARED_1, 16'h0008);
        repeat (2) @(posedge clk_i);
        conclude();
    end
endmodule

// ---- tb/periph_model.sv ----
// peripheral side: request lines and indirect offset
module periph_model (
    input  wire logic         clk_i,
    input  wire logic         fire_i,   // one-cycle request
    input  wire logic [6:0]   line_i,   // request number
    input  wire logic [15:0]  off_i,    // indirect offset
    output logic [127:0]      req_vec_o = 128'h0,
    output logic [15:0]       periph_off_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // ******************************************
    // one line rises per fire, falls next cycle
    // ******************************************
    always @(posedge clk_i)
    begin
        req_vec_o <= fire_i ? (128'h1 << line_i) : 128'h0;
        periph_off_o <= off_i;
    end
endmodule
